// File: hw/swt_pkg.sv
// swt_pkg: constants for the single-wire thermometer slave logic.
// assumes a 100 MHz clock; slot and reset times are counted from line falling edges, presence times from reset release.
package swt_pkg;
   localparam int CLK_MHZ        = 100;
   // slot and framing times in microseconds
   localparam int RST_MIN_US     = 480;
   localparam int PRES_WAIT_US   = 30;
   localparam int PRES_LEN_US    = 120;
   localparam int SAMPLE_US      = 30;
   localparam int HOLD_US        = 15;
   localparam int RST_CYC        = RST_MIN_US * CLK_MHZ;
   localparam int PRES_WAIT_CYC  = PRES_WAIT_US * CLK_MHZ;
   localparam int PRES_LEN_CYC   = PRES_LEN_US * CLK_MHZ;
   localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
   localparam int HOLD_CYC       = HOLD_US * CLK_MHZ;
   localparam int CNT_W          = 16;
   // command codes
   localparam logic [7:0] CMD_MATCH   = 8'h55;
   localparam logic [7:0] CMD_SKIP    = 8'hcc;
   localparam logic [7:0] CMD_CONV    = 8'h44;
   localparam logic [7:0] CMD_RDSP    = 8'hbe;
   localparam logic [7:0] CMD_WRSP    = 8'h4e;
   localparam logic [7:0] CMD_COPY    = 8'h48;
   localparam logic [7:0] CMD_RECALL  = 8'hb8;
   localparam logic [7:0] CMD_PWR     = 8'hb4;
   localparam int         SP_BYTES    = 9;
   localparam int         ADDR_BITS   = 64;

   typedef enum logic [2:0] {
      SWT_ROM    = 3'b000,
      SWT_MATCH  = 3'b001,
      SWT_FUNC   = 3'b011,
      SWT_RDSP   = 3'b010,
      SWT_WRSP   = 3'b110,
      SWT_STAT   = 3'b111,
      SWT_IDLE   = 3'b101
   } swt_phase_e;
endpackage : swt_pkg

// File: hw/swt_slot_if.sv
// swt_slot_if: bit-level events between slot timer and transaction logic.
// assumes one clock domain shared by both modules.
`timescale 1ns/100ps
interface swt_slot_if;
   logic rst_seen;   // reset pulse detected, one cycle
   logic bit_valid;  // a slot's sampled bit, one cycle
   logic bit_val;    // value of the sampled bit
   logic tx_bit;     // bit to return in the next read slot
   logic tx_en;      // transaction logic wants to answer slots
   logic slot_start; // a slot began, one cycle
   modport timer (output rst_seen, output bit_valid, output bit_val, output slot_start,
                  input tx_bit, input tx_en);
   modport ctrl  (input rst_seen, input bit_valid, input bit_val, input slot_start,
                  output tx_bit, output tx_en);
endinterface : swt_slot_if

// File: hw/swt_slot.sv
// swt_slot: times slots and reset from falling edges of the line, presence from reset release.
// assumes the line input is already synchronous to clk.
`timescale 1ns/100ps
module swt_slot
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      resetn,
   // line
   input  wire logic      dq_in,
   output logic           dq_oe,
   // events
   swt_slot_if.timer      sl
);
   logic                          dq_q;
   logic [swt_pkg::CNT_W-1:0]     low_cnt;
   logic [swt_pkg::CNT_W-1:0]     slot_cnt;
   logic                          in_slot;
   logic                          drive_zero;
   logic [swt_pkg::CNT_W-1:0]     pres_cnt;
   logic                          pres_act;
   logic                          fall;

   assign fall = dq_q & ~dq_in;

   // edge history and low-time counter for reset detection
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         dq_q    <= 1'b1;
         low_cnt <= '0;
      end
      else
      begin
         dq_q    <= dq_in;
         low_cnt <= dq_in ? '0 : (low_cnt == '1 ? low_cnt : low_cnt + 1'b1);
      end
   end
   assign sl.rst_seen = dq_in & ~dq_q & ~pres_act
                        & (low_cnt >= swt_pkg::CNT_W'(swt_pkg::RST_CYC));

   // slot timer; drives only inside a slot the master opened
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         in_slot    <= 1'b0;
         slot_cnt   <= '0;
         drive_zero <= 1'b0;
      end
      else if (fall && !pres_act)
      begin
         in_slot    <= 1'b1;
         slot_cnt   <= '0;
         drive_zero <= sl.tx_en & ~sl.tx_bit;
      end
      else if (in_slot)
      begin
         slot_cnt <= slot_cnt + 1'b1;
         if (slot_cnt == swt_pkg::CNT_W'(swt_pkg::HOLD_CYC - 1))
            drive_zero <= 1'b0;
         if (slot_cnt == swt_pkg::CNT_W'(swt_pkg::SAMPLE_CYC - 1))
            in_slot <= 1'b0;
      end
   end
   assign sl.slot_start = fall & ~pres_act;
   assign sl.bit_valid  = in_slot & (slot_cnt == swt_pkg::CNT_W'(swt_pkg::SAMPLE_CYC - 1));
   assign sl.bit_val    = dq_in;

   // presence pulse after reset release
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pres_act <= 1'b0;
         pres_cnt <= '0;
      end
      else if (sl.rst_seen)
      begin
         pres_act <= 1'b1;
         pres_cnt <= '0;
      end
      else if (pres_act)
      begin
         pres_cnt <= pres_cnt + 1'b1;
         if (pres_cnt == swt_pkg::CNT_W'(swt_pkg::PRES_WAIT_CYC + swt_pkg::PRES_LEN_CYC - 1))
            pres_act <= 1'b0;
      end
   end

   assign dq_oe = (drive_zero & in_slot)
                | (pres_act & (pres_cnt >= swt_pkg::CNT_W'(swt_pkg::PRES_WAIT_CYC)));
endmodule : swt_slot

// File: hw/swt_top.sv
// swt_top: transaction logic of the single-wire thermometer slave.
// assumes clean synchronous line input; external pullup; strong pullup is the master's job.
`timescale 1ns/100ps
module swt_top #(
   parameter logic [63:0] DEV_CODE  = 64'h0000_0000_0000_0001, // arbitrary value
   parameter int          CONV_CYC  = 1000,
   parameter int          NV_CYC    = 1000
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // line, open drain
   input  wire logic        dq_in,
   output logic             dq_out,
   output logic             dq_oe,
   // sensor side
   input  wire logic        parasite,
   input  wire logic [15:0] temp_in,
   output logic             conv_busy,
   output logic [7:0]       alarm_hi,
   output logic [7:0]       alarm_lo
);
   swt_slot_if sl ();

   swt_pkg::swt_phase_e        ph_reg;
   logic [7:0]                 sh_reg;
   logic [6:0]                 bcnt_reg;
   logic                       match_ok_reg;
   logic [7:0]                 sp_reg [swt_pkg::SP_BYTES];
   logic [7:0]                 nv_hi_reg;
   logic [7:0]                 nv_lo_reg;
   logic [31:0]                busy_cnt_reg;
   logic                       restore_reg;
   logic [7:0]                 crc_reg;
   logic [7:0]                 byte_now;
   logic [7:0]                 sh_new;
   logic [7:0]                 crc_next;

   swt_slot u_slot (
      .clk    (clk),
      .resetn (resetn),
      .dq_in  (dq_in),
      .dq_oe  (dq_oe),
      .sl     (sl)
   );

   assign dq_out = 1'b0;
   assign sh_new = {sl.bit_val, sh_reg[7:1]};

   // byte currently being returned, crc replaces byte eight
   always_comb
   begin
      byte_now = sp_reg[bcnt_reg[6:3]];
      if (bcnt_reg[6:3] == 4'(swt_pkg::SP_BYTES - 1))
         byte_now = crc_reg;
   end

   // outgoing bit for the next slot
   always_comb
   begin
      sl.tx_en  = 1'b0;
      sl.tx_bit = 1'b1;
      unique case (ph_reg)
         swt_pkg::SWT_RDSP:
         begin
            sl.tx_en  = 1'b1;
            sl.tx_bit = byte_now[bcnt_reg[2:0]];
         end
         swt_pkg::SWT_STAT:
         begin
            sl.tx_en  = 1'b1;
            sl.tx_bit = (busy_cnt_reg == 32'h0);
         end
         swt_pkg::SWT_IDLE:
         begin
            sl.tx_en  = restore_reg;                          // supply answer
            sl.tx_bit = ~parasite;
         end
         default:
         begin
            sl.tx_en  = 1'b0;
            sl.tx_bit = 1'b1;
         end
      endcase
   end

   // reflected crc8 over bytes 0..7, x^8+x^5+x^4+1
   always_comb
   begin
      crc_next = 8'h00;
      for (int b = 0; b < 8; b++)
         for (int i = 0; i < 8; i++)
            crc_next = (crc_next[0] ^ sp_reg[b][i]) ? ((crc_next >> 1) ^ 8'h8c)
                                                    : (crc_next >> 1);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         crc_reg <= 8'h00;
      else
         crc_reg <= crc_next;
   end

   // transaction state: reset, address, function, payload
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ph_reg       <= swt_pkg::SWT_IDLE;
         sh_reg       <= 8'h00;
         bcnt_reg     <= '0;
         match_ok_reg <= 1'b1;
         restore_reg  <= 1'b0;
      end
      else if (sl.rst_seen)
      begin
         ph_reg       <= swt_pkg::SWT_ROM;
         bcnt_reg     <= '0;
         match_ok_reg <= 1'b1;
         restore_reg  <= 1'b0;
      end
      else if (sl.bit_valid)
      begin
         sh_reg   <= sh_new;
         bcnt_reg <= bcnt_reg + 1'b1;
         unique case (ph_reg)
            swt_pkg::SWT_ROM:
               if (bcnt_reg == 7'd7)
               begin
                  bcnt_reg <= '0;
                  if (sh_new == swt_pkg::CMD_SKIP)
                     ph_reg <= swt_pkg::SWT_FUNC;
                  else if (sh_new == swt_pkg::CMD_MATCH)
                     ph_reg <= swt_pkg::SWT_MATCH;
                  else
                     ph_reg <= swt_pkg::SWT_IDLE;
               end
            swt_pkg::SWT_MATCH:
            begin
               if (sl.bit_val != DEV_CODE[bcnt_reg[5:0]])
                  match_ok_reg <= 1'b0;
               if (bcnt_reg == 7'(swt_pkg::ADDR_BITS - 1))
               begin
                  bcnt_reg <= '0;
                  ph_reg   <= (match_ok_reg && sl.bit_val == DEV_CODE[63])
                              ? swt_pkg::SWT_FUNC : swt_pkg::SWT_IDLE;
               end
            end
            swt_pkg::SWT_FUNC:
               if (bcnt_reg == 7'd7)
               begin
                  bcnt_reg <= '0;
                  unique case (sh_new)
                     swt_pkg::CMD_RDSP:   ph_reg <= swt_pkg::SWT_RDSP;
                     swt_pkg::CMD_WRSP:   ph_reg <= swt_pkg::SWT_WRSP;
                     swt_pkg::CMD_CONV,
                     swt_pkg::CMD_RECALL: ph_reg <= swt_pkg::SWT_STAT;
                     swt_pkg::CMD_PWR:
                     begin
                        ph_reg      <= swt_pkg::SWT_IDLE;
                        restore_reg <= 1'b1;
                     end
                     default:             ph_reg <= swt_pkg::SWT_IDLE;
                  endcase
               end
            swt_pkg::SWT_RDSP:
               if (bcnt_reg == 7'(swt_pkg::SP_BYTES * 8 - 1))
                  ph_reg <= swt_pkg::SWT_IDLE;
            swt_pkg::SWT_WRSP:
               if (bcnt_reg == 7'd15)
                  ph_reg <= swt_pkg::SWT_IDLE;
            swt_pkg::SWT_STAT:
               bcnt_reg <= '0;
            swt_pkg::SWT_IDLE:
            begin
               bcnt_reg    <= '0;
               restore_reg <= 1'b0;                            // single supply answer
            end
            default:
               ph_reg <= swt_pkg::SWT_IDLE;
         endcase
      end
   end

   // scratchpad and nonvolatile alarm copy
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < swt_pkg::SP_BYTES; i++)
            sp_reg[i] <= 8'h00;
         nv_hi_reg    <= 8'h00;
         nv_lo_reg    <= 8'h00;
         busy_cnt_reg <= 32'h0;
      end
      else
      begin
         if (busy_cnt_reg != 32'h0)
            busy_cnt_reg <= busy_cnt_reg - 32'h1;
         if (sl.bit_valid && ph_reg == swt_pkg::SWT_WRSP && bcnt_reg[2:0] == 3'd7)
            sp_reg[2 + 32'(bcnt_reg[3])] <= sh_new;
         if (sl.bit_valid && ph_reg == swt_pkg::SWT_FUNC && bcnt_reg == 7'd7)
         begin
            if (sh_new == swt_pkg::CMD_CONV)
            begin
               busy_cnt_reg <= 32'(CONV_CYC);
               sp_reg[0]    <= temp_in[7:0];
               sp_reg[1]    <= temp_in[15:8];
            end
            else if (sh_new == swt_pkg::CMD_RECALL)
            begin
               busy_cnt_reg <= 32'(NV_CYC);
               sp_reg[2]    <= nv_hi_reg;
               sp_reg[3]    <= nv_lo_reg;
            end
            else if (sh_new == swt_pkg::CMD_COPY)
            begin
               nv_hi_reg <= sp_reg[2];
               nv_lo_reg <= sp_reg[3];
            end
         end
      end
   end

   assign conv_busy = (busy_cnt_reg != 32'h0);
   assign alarm_hi  = sp_reg[2];
   assign alarm_lo  = sp_reg[3];
endmodule : swt_top

// File: verif/swt_chk.sv
// swt_chk: port-level checks on the single-wire thermometer slave.
// assumes the bench resolves the line with a pullup and runs clk at 100 MHz.
`timescale 1ns/100ps
module swt_chk #(
   parameter int CONV_CYC = 1000,
   parameter int NV_CYC   = 1000
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // line and status
   input  wire logic dq_in,
   input  wire logic dq_out,
   input  wire logic dq_oe,
   input  wire logic conv_busy
);
   // --------------------------------
   // run-length helpers
   // --------------------------------
   logic        in_reg;
   logic [15:0] low_reg;
   logic [15:0] rst_reg;
   logic [15:0] oe_reg;
   logic [15:0] busy_reg;

   // low_reg and rst_reg saturate so a long idle line never wraps into a false match
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         in_reg   <= 1'b1;
         low_reg  <= 16'h0;
         rst_reg  <= 16'hffff;
         oe_reg   <= 16'h0;
         busy_reg <= 16'h0;
      end
      else
      begin
         in_reg   <= dq_in;
         low_reg  <= dq_in ? 16'h0 : low_reg + {15'h0, low_reg != 16'hffff};
         rst_reg  <= (dq_in && !in_reg && low_reg >= 16'd48000) ? 16'h0
                     : rst_reg + {15'h0, rst_reg != 16'hffff};
         oe_reg   <= dq_oe ? oe_reg + 16'h1 : 16'h0;
         busy_reg <= conv_busy ? busy_reg + 16'h1 : 16'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // --------------------------------
   // assertions
   // --------------------------------
   a_out_low: assert property (dq_out == 1'b0)
      else $error("data output not held low");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !dq_oe)
      else $error("line driven around reset");
   a_zero_edge: assert property ($rose(dq_oe) && !$past(dq_in) |-> $past(dq_in, 2))
      else $error("zero drive not one cycle after the fall");
   a_pres_delay: assert property ($rose(dq_oe) && $past(dq_in)
      |-> rst_reg >= 16'd1500 && rst_reg <= 16'd6000)
      else $error("drive on idle line outside presence window");
   a_drive_len: assert property ($fell(dq_oe) |-> oe_reg == 16'd1500
      || (oe_reg >= 16'd6000 && oe_reg <= 16'd24000))
      else $error("drive length wrong");
   a_drive_min: assert property ($rose(dq_oe) |=> dq_oe [*8])
      else $error("drive glitch");
   a_long_idle: assert property (low_reg > 16'd24100 |-> !dq_oe)
      else $error("drive during long low");
   a_busy_len: assert property ($fell(conv_busy) |-> busy_reg inside
      {[CONV_CYC-1:CONV_CYC+1], [NV_CYC-1:NV_CYC+1]})
      else $error("busy length wrong");
endmodule : swt_chk

// File: verif/swt_master.sv
// swt_master: behavioural bus master for the single data line.
// assumes a pullup on the line and a 100 MHz clk; drives 1 ns after edges.
`timescale 1ns/100ps
module swt_master
(
   // clock
   input  wire logic clk,
   // line
   input  wire logic dq,
   output logic      m_oe,
   // received bytes
   output logic      got_valid,
   output logic [7:0] got_byte
);
   initial
   begin
      m_oe      = 1'b0;
      got_valid = 1'b0;
      got_byte  = 8'h00;
   end

   // wait n edges, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // one slot; a read is a write of one with a sample 13 us after the fall
   task automatic slot(input logic wb, output logic rb);
      tick(1);
      m_oe = 1'b1;
      tick(wb ? 200 : 6000);
      m_oe = 1'b0;
      tick(wb ? 1100 : 0);
      rb = dq;
      tick(wb ? 4900 : 200);
   endtask : slot

   // reset pulse, then watch for presence
   task automatic bus_reset(output logic pres);
      pres = 1'b0;
      tick(1);
      m_oe = 1'b1;
      tick(48100);
      m_oe = 1'b0;
      repeat (16000) // presence ends 150 us after release
      begin
         tick(1);
         if (!dq)
            pres = 1'b1;
      end
   endtask : bus_reset

   task automatic wbyte(input logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++)
         slot(v[i], r);
   endtask : wbyte

   // bits arrive lsb first; result shown for one cycle
   task automatic rbyte(output logic [7:0] v);
      for (int i = 0; i < 8; i++)
         slot(1'b1, v[i]);
      got_byte  = v;
      got_valid = 1'b1;
      tick(1);
      got_valid = 1'b0;
   endtask : rbyte
endmodule : swt_master

// File: verif/swt_top_tb_top.sv
// swt_top_tb_top: self-checking bench for the thermometer slave.
// assumes swt_pkg, swt_slot_if, swt_slot, swt_top and the bench files compiled.
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module swt_top_tb_top;
   localparam logic [63:0] CODE = 64'h0000_0000_0000_0001; // arbitrary value
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        parasite = 1'b0;
   logic [15:0] temp_in = 16'h0;
   logic        dq, dq_out, dq_oe, conv_busy, m_oe, got_valid, b, pres;
   logic [7:0]  alarm_hi, alarm_lo, got_byte, bv, rd, hi, lo, crc;
   logic [15:0] exp_q [$];
   logic [31:0] rnd = 32'd98;
   int          err_total = 0;
   int          total_checks = 0;

   always #5 clk = ~clk;
   assign dq = !(m_oe || dq_oe); // pullup wins unless a party pulls low

   swt_top #(.DEV_CODE(CODE), .CONV_CYC(8000), .NV_CYC(8000)) DUT (.clk(clk),
      .resetn(resetn), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .parasite(parasite),
      .temp_in(temp_in), .conv_busy(conv_busy), .alarm_hi(alarm_hi), .alarm_lo(alarm_lo));
   swt_master u_m (.clk(clk), .dq(dq), .m_oe(m_oe), .got_valid(got_valid),
      .got_byte(got_byte));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
      return c;
   endfunction : crc8

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic open_skip(input logic [7:0] cmd);
      u_m.bus_reset(pres);
      `CHK("presence", 1'b1, pres)
      u_m.wbyte(swt_pkg::CMD_SKIP);
      u_m.wbyte(cmd);
   endtask : open_skip

   task automatic st(input logic e);
      u_m.slot(1'b1, b);
      `CHK("status_bit", e, b)
   endtask : st

   // monitor: upper half of a note masks bytes with no fixed value
   always @(posedge clk)
      if (got_valid === 1'b1)
      begin
         `CHK("rd_byte", exp_q[0][7:0], got_byte & exp_q[0][15:8])
         void'(exp_q.pop_front());
      end

   // a hang counts as a mismatch
   initial
   begin
      #70_000_000;
      err_total++;
      final_report();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      resetn = 1'b1;
      rnd = xs(rnd);
      temp_in = rnd[15:0];
      hi = rnd[23:16];
      lo = rnd[31:24];
      open_skip(swt_pkg::CMD_CONV);
      st(1'b0);
      st(1'b1);
      open_skip(swt_pkg::CMD_WRSP);
      u_m.wbyte(hi);
      u_m.wbyte(lo);
      `CHK("alarm_hi", hi, alarm_hi)
      `CHK("alarm_lo", lo, alarm_lo)
      open_skip(swt_pkg::CMD_RDSP);
      crc = 8'h00;
      for (int i = 0; i < 9; i++)
      begin
         case (i)
            0: bv = temp_in[7:0];
            1: bv = temp_in[15:8];
            2: bv = hi;
            3: bv = lo;
            8: bv = crc;
            default: bv = 8'h00;
         endcase
         exp_q.push_back({(i > 3 && i < 8) ? 8'h00 : 8'hff, bv});
         u_m.rbyte(rd);
         crc = crc8(crc, (i > 3) ? rd : bv);
      end
      // read cut short; the next reset must still restart the slave
      open_skip(swt_pkg::CMD_RDSP);
      exp_q.push_back({8'hff, temp_in[7:0]});
      u_m.rbyte(rd);
      // own code with parasite, foreign code, own code with supply
      for (int k = 0; k < 3; k++)
      begin
         parasite = (k != 2);
         u_m.bus_reset(pres);
         u_m.wbyte(swt_pkg::CMD_MATCH);
         for (int j = 0; j < 8; j++)
            u_m.wbyte(CODE[8*j +: 8] ^ {7'h0, k == 1});
         u_m.wbyte(swt_pkg::CMD_PWR);
         st(k != 0);
      end
      // parasite conversion: line left idle high through the conversion time
      parasite = 1'b1;
      open_skip(swt_pkg::CMD_CONV);
      `CHK("conv_busy", 1'b1, conv_busy)
      u_m.tick(8100);
      `CHK("conv_busy", 1'b0, conv_busy)
      // copy alarms, overwrite them, then restore them from the copy
      open_skip(swt_pkg::CMD_COPY);
      u_m.tick(1_000_000);
      open_skip(swt_pkg::CMD_WRSP);
      u_m.wbyte(~hi);
      u_m.wbyte(~lo);
      `CHK("alarm_hi", ~hi, alarm_hi)
      open_skip(swt_pkg::CMD_RECALL);
      st(1'b0);
      st(1'b1);
      `CHK("alarm_hi", hi, alarm_hi)
      `CHK("alarm_lo", lo, alarm_lo)
      final_report();
   end
endmodule : swt_top_tb_top

bind swt_top swt_chk #(.CONV_CYC(8000), .NV_CYC(8000)) u_chk (.clk(clk), .resetn(resetn),
   .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .conv_busy(conv_busy));
